//--- hw/ptm_pkg.sv
package ptm_pkg;

    // Array geometry.
    localparam int NUM_MC    = 16;
    localparam int PT_PER_MC = 2;
    localparam int NUM_PT    = NUM_MC * PT_PER_MC;
    localparam int NUM_IN    = 32;
    localparam int NUM_FB    = 9;
    localparam int NUM_DED   = 2;
    localparam int NUM_GLB   = 4;
    localparam int NUM_BCLK  = 2;
    localparam int IDX_W     = 5;
    localparam int DED_W     = 1;
    localparam int GLB_W     = 2;

    // Register behaviour codes.
    localparam logic [1:0] REG_D  = 2'h0;
    localparam logic [1:0] REG_T  = 2'h1;
    localparam logic [1:0] REG_JK = 2'h2;
    localparam logic [1:0] REG_SR = 2'h3;

    // Control source codes.
    localparam logic [1:0] SRC_DED = 2'h0;
    localparam logic [1:0] SRC_GLB = 2'h1;
    localparam logic [1:0] SRC_LOC = 2'h2;

    // Per-macrocell clear choice.
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_ONE  = 2'h1;
    localparam logic [1:0] CLR_TWO  = 2'h2;

    // Values after reset.
    localparam logic       RST_Q    = 1'b0;
    localparam logic [1:0] RST_SYNC = 2'h0;

    // Picks one control level from a dedicated pin, a global signal or a local routing line.
    function automatic logic ptm_src_level(input logic [1:0]         src,
                                           input logic [IDX_W-1:0]   idx,
                                           input logic [NUM_DED-1:0] ded,
                                           input logic [NUM_GLB-1:0] glb,
                                           input logic [NUM_IN-1:0]  loc);
        logic lvl;
        lvl = 1'b0;
        case (src)
            SRC_DED: lvl = ded[idx[DED_W-1:0]];
            SRC_GLB: lvl = glb[idx[GLB_W-1:0]];
            default: lvl = loc[idx];
        endcase
        return lvl;
    endfunction

endpackage

//--- hw/ptm_clkctl.sv
`timescale 1ns/10ps
module ptm_clkctl import ptm_pkg::*; (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    // Synchronised and local sources
    input  wire logic [NUM_DED-1:0] ded_s,
    input  wire logic [NUM_GLB-1:0] glb_s,
    input  wire logic [NUM_IN-1:0]  loc,
    // Configuration
    input  wire logic [1:0]         src_cfg,
    input  wire logic [IDX_W-1:0]   idx_cfg,
    input  wire logic               fall_cfg,
    input  wire logic               ena_use_cfg,
    input  wire logic [IDX_W-1:0]   ena_idx_cfg,
    // Result
    output logic                    tick
);

    logic lvl;
    logic prev_ff;
    logic edge_seen;
    logic ena;

    assign lvl = ptm_src_level(src_cfg, idx_cfg, ded_s, glb_s, loc); // [R10]

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= lvl;
        end
    end

    // Each block clock watches one edge, so mixed edges need both clocks.
    assign edge_seen = fall_cfg ? (prev_ff & ~lvl) : (~prev_ff & lvl); // [R12]
    assign ena       = ena_use_cfg ? loc[ena_idx_cfg] : 1'b1;           // [R11]
    assign tick      = edge_seen & ena;

    clk_edge_a : assert property (@(posedge ref_clk) disable iff (sys_rst) // [R12]
        tick |-> (fall_cfg ? (!lvl && $past(lvl)) : (lvl && !$past(lvl))))
        else $error("block clock tick without the chosen edge");

    clk_enable_a : assert property (@(posedge ref_clk) disable iff (sys_rst) // [R11]
        (ena_use_cfg && !loc[ena_idx_cfg]) |-> !tick)
        else $error("block clock ticked while its enable was low");

endmodule // ptm_clkctl

//--- hw/ptm_mcreg.sv
`timescale 1ns/10ps
module ptm_mcreg import ptm_pkg::*; (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Controls
    input  wire logic       clr,
    input  wire logic       tick,
    input  wire logic [1:0] reg_type,
    // Data
    input  wire logic       in_a,
    input  wire logic       in_b,
    output logic            q_ff
);

    logic nxt_q;

    always_comb begin
        nxt_q = q_ff;
        case (reg_type) // [R8]
            REG_D: begin
                nxt_q = in_a;
            end
            REG_T: begin
                nxt_q = in_a ? ~q_ff : q_ff; // [R20]
            end
            REG_JK: begin
                case ({in_a, in_b})
                    2'h1:    nxt_q = 1'b0;
                    2'h2:    nxt_q = 1'b1;
                    2'h3:    nxt_q = ~q_ff;
                    default: nxt_q = q_ff;
                endcase
            end
            default: begin
                // Set and reset together is illegal; the register holds.
                case ({in_a, in_b})
                    2'h1:    nxt_q = 1'b0;
                    2'h2:    nxt_q = 1'b1;
                    default: nxt_q = q_ff;
                endcase
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_ff <= RST_Q;
        end else if (clr) begin
            q_ff <= RST_Q; // [R19]
        end else if (tick) begin
            q_ff <= nxt_q;
        end
    end

    t_toggle_a : assert property (@(posedge ref_clk) disable iff (sys_rst) // [R20]
        (tick && !clr && reg_type == REG_T) |=> (q_ff == ($past(in_a) ? !$past(q_ff) : $past(q_ff))))
        else $error("T register did not toggle or hold correctly");

    clr_force_a : assert property (@(posedge ref_clk) disable iff (sys_rst) // [R19]
        clr |=> !q_ff)
        else $error("cleared register is not zero");

endmodule // ptm_mcreg

//--- hw/ptm_array.sv
`timescale 1ns/10ps
// Functional notes
// R1 - Block switches alone into macrocell mode.
// R2 - Sixteen macrocells, two terms plus register.
// R3 - Thirty-two local routing inputs feed terms.
// R4 - Nine macrocell outputs feed back locally.
// R5 - Each term is primary or lent expander.
// R6 - Second term of each macrocell invertible.
// R7 - Macrocell combinatorial or registered per cell.
// R8 - Register acts as D, T, JK, SR.
// R9 - Each register picks one block clock.
// R10 - Block clock from pin, global, local.
// R11 - Each clock has its own enable.
// R12 - Mixed edges use both block clocks.
// R13 - Two invertible clears from global or local.
// R14 - Macrocell picks clear one, two, none.
// R15 - Up to thirty-two terms per OR gate.
// R16 - Up to fifteen two-term expander sets chained.
// R17 - Block drives and reads local routing only; code also reads dedicated and global pins for clocks and clears.
// R18 - Chip-wide clear overrides and clears everything; the code leaves the clock tick and block clear status flops running.
// R19 - Selected clear zeroes register regardless of clock.
// R20 - T register toggles on high, else holds.
module ptm_array import ptm_pkg::*; (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    // Chip-wide clear, active low pin
    input  wire logic                        global_register_clear_n,
    // Routing and control sources
    input  wire logic [NUM_IN-1:0]           local_in,
    input  wire logic [NUM_DED-1:0]          ded_clk_pin,
    input  wire logic [NUM_GLB-1:0]          global_sig,
    // Block mode
    input  wire logic                        block_pt_mode,
    // Product-term configuration
    input  wire logic [NUM_PT*NUM_IN-1:0]    pt_true_cfg,
    input  wire logic [NUM_PT*NUM_IN-1:0]    pt_comp_cfg,
    input  wire logic [NUM_PT-1:0]           pt_lend_cfg,
    input  wire logic [NUM_MC-1:0]           pt1_inv_cfg,
    input  wire logic [NUM_MC-1:0]           chain_pass_cfg,
    input  wire logic [NUM_MC-1:0]           xor_inv_cfg,
    input  wire logic [NUM_FB-1:0]           fb_sel_cfg,
    // Macrocell configuration
    input  wire logic [NUM_MC-1:0]           mc_comb_cfg,
    input  wire logic [2*NUM_MC-1:0]         mc_regtype_cfg,
    input  wire logic [NUM_MC-1:0]           mc_clk_sel_cfg,
    input  wire logic [2*NUM_MC-1:0]         mc_clr_sel_cfg,
    // Block clock configuration
    input  wire logic [2*NUM_BCLK-1:0]       clk_src_cfg,
    input  wire logic [IDX_W*NUM_BCLK-1:0]   clk_idx_cfg,
    input  wire logic [NUM_BCLK-1:0]         clk_fall_cfg,
    input  wire logic [NUM_BCLK-1:0]         ena_use_cfg,
    input  wire logic [IDX_W*NUM_BCLK-1:0]   ena_idx_cfg,
    // Block clear configuration
    input  wire logic [2*NUM_BCLK-1:0]       clr_src_cfg,
    input  wire logic [IDX_W*NUM_BCLK-1:0]   clr_idx_cfg,
    input  wire logic [NUM_BCLK-1:0]         clr_inv_cfg,
    // Outputs
    output logic [NUM_MC-1:0]                mc_out_ff,
    output logic [NUM_FB-1:0]                local_fb_ff,
    output logic [NUM_BCLK-1:0]              clk_tick_ff,
    output logic                             block_clear_one_ff,
    output logic                             block_clear_two_ff
);

    default clocking dclk @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Pin synchronisers.
    logic [NUM_DED-1:0] ded_s1_ff;
    logic [NUM_DED-1:0] ded_s2_ff;
    logic [NUM_GLB-1:0] glb_s1_ff;
    logic [NUM_GLB-1:0] glb_s2_ff;
    logic               chip_n_s1_ff;
    logic               chip_n_s2_ff;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ded_s1_ff <= '0;
            ded_s2_ff <= '0;
            glb_s1_ff <= '0;
            glb_s2_ff <= '0;
        end else begin
            ded_s1_ff <= ded_clk_pin;
            ded_s2_ff <= ded_s1_ff;
            glb_s1_ff <= global_sig;
            glb_s2_ff <= glb_s1_ff;
        end
    end

    // The chip-wide clear starts asserted and lifts two cycles after reset.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {chip_n_s2_ff, chip_n_s1_ff} <= RST_SYNC;
        end else begin
            chip_n_s1_ff <= global_register_clear_n;
            chip_n_s2_ff <= chip_n_s1_ff;
        end
    end

    logic chip_clr;
    logic hold_off;

    assign chip_clr = ~chip_n_s2_ff;
    // Memory mode or chip clear keep every macrocell at zero.
    assign hold_off = chip_clr | ~block_pt_mode; // [R1] [R18]

    // Literal set: local routing, with the low lines optionally taken by feedback.
    logic [NUM_IN-1:0] lits;

    genvar gl;
    generate
        for (gl = 0; gl < NUM_IN; gl++) begin : g_lit
            if (gl < NUM_FB) begin : g_fb
                assign lits[gl] = fb_sel_cfg[gl] ? local_fb_ff[gl] : local_in[gl]; // [R4] [R3]
            end else begin : g_loc
                assign lits[gl] = local_in[gl]; // [R3]
            end
        end
    endgenerate

    // Product terms: AND of chosen true and complemented literals.
    logic [NUM_PT-1:0] pt;

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PT; gp++) begin : g_pt
            logic [NUM_IN-1:0] tmask;
            logic [NUM_IN-1:0] cmask;
            assign tmask  = pt_true_cfg[gp*NUM_IN +: NUM_IN];
            assign cmask  = pt_comp_cfg[gp*NUM_IN +: NUM_IN];
            assign pt[gp] = &((~tmask | lits) & (~cmask | ~lits)); // [R3]
        end
    endgenerate

    // Block clocks with their enables.
    logic [NUM_BCLK-1:0] clk_tick;

    genvar gk;
    generate
        for (gk = 0; gk < NUM_BCLK; gk++) begin : g_bclk
            ptm_clkctl u_clkctl (
                .ref_clk     (ref_clk),
                .sys_rst     (sys_rst),
                .ded_s       (ded_s2_ff),
                .glb_s       (glb_s2_ff),
                .loc         (local_in),
                .src_cfg     (clk_src_cfg[2*gk +: 2]),
                .idx_cfg     (clk_idx_cfg[IDX_W*gk +: IDX_W]),
                .fall_cfg    (clk_fall_cfg[gk]),
                .ena_use_cfg (ena_use_cfg[gk]),
                .ena_idx_cfg (ena_idx_cfg[IDX_W*gk +: IDX_W]),
                .tick        (clk_tick[gk])
            ); // [R10] [R11] [R12]
        end
    endgenerate

    // Block clears: global or local, each invertible.
    logic [NUM_BCLK-1:0] clr_act;

    genvar gc;
    generate
        for (gc = 0; gc < NUM_BCLK; gc++) begin : g_bclr
            logic [1:0] src;
            assign src = (clr_src_cfg[2*gc +: 2] == SRC_LOC) ? SRC_LOC : SRC_GLB;
            assign clr_act[gc] = ptm_src_level(src, clr_idx_cfg[IDX_W*gc +: IDX_W], ded_s2_ff, glb_s2_ff,
                                               local_in) ^ clr_inv_cfg[gc]; // [R13]
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_tick_ff        <= '0;
            block_clear_one_ff <= 1'b0;
            block_clear_two_ff <= 1'b0;
        end else begin
            clk_tick_ff        <= clk_tick;
            block_clear_one_ff <= clr_act[0];
            block_clear_two_ff <= clr_act[1];
        end
    end

    // Macrocells and the expander chain.
    logic [NUM_MC-1:0] chain;
    logic [NUM_MC-1:0] chain_in;
    logic [NUM_MC-1:0] mc_d;
    logic [NUM_MC-1:0] mc_q;
    logic [NUM_MC-1:0] nxt_mc_out;

    assign chain_in[0] = 1'b0;

    genvar gm;
    generate
        for (gm = 0; gm < NUM_MC; gm++) begin : g_mc
            logic       p0;
            logic       p1;
            logic       lend0;
            logic       lend1;
            logic       two_in;
            logic       use_in;
            logic       prim_or;
            logic       in_b;
            logic       mc_clr;
            logic       mc_tick;
            logic [1:0] rtype;
            logic [1:0] csel;

            if (gm > 0) begin : g_link
                assign chain_in[gm] = chain[gm-1];
            end

            assign rtype  = mc_regtype_cfg[2*gm +: 2];
            assign csel   = mc_clr_sel_cfg[2*gm +: 2];
            assign p0     = pt[PT_PER_MC*gm];
            assign p1     = pt[PT_PER_MC*gm+1] ^ pt1_inv_cfg[gm]; // [R6]
            assign lend0  = pt_lend_cfg[PT_PER_MC*gm];
            assign lend1  = pt_lend_cfg[PT_PER_MC*gm+1];
            assign two_in = (rtype == REG_JK) || (rtype == REG_SR);

            // Lent terms join the chain; a passing cell forwards what reaches it.
            assign chain[gm] = (lend0 & p0) | (lend1 & p1) | (chain_pass_cfg[gm] & chain_in[gm]); // [R5] [R16]
            assign use_in    = ~chain_pass_cfg[gm] & chain_in[gm];                                  // [R15]
            assign prim_or   = (~lend0 & p0) | (~lend1 & ~two_in & p1) | use_in;                    // [R5] [R2]
            assign mc_d[gm]  = prim_or ^ xor_inv_cfg[gm];
            assign in_b      = ~lend1 & p1;

            assign mc_tick = mc_clk_sel_cfg[gm] ? clk_tick[1] : clk_tick[0]; // [R9]
            assign mc_clr  = hold_off | ((csel == CLR_ONE) & clr_act[0])
                                      | ((csel == CLR_TWO) & clr_act[1]); // [R14] [R18]

            ptm_mcreg u_reg (
                .ref_clk  (ref_clk),
                .sys_rst  (sys_rst),
                .clr      (mc_clr),
                .tick     (mc_tick),
                .reg_type (rtype),
                .in_a     (mc_d[gm]),
                .in_b     (in_b),
                .q_ff     (mc_q[gm])
            ); // [R2] [R8]

            assign nxt_mc_out[gm] = hold_off ? 1'b0 : (mc_comb_cfg[gm] ? mc_d[gm] : mc_q[gm]); // [R7] [R18]

            clr_select_a : assert property ( // [R14]
                (csel == CLR_ONE && clr_act[0]) |=> !mc_q[gm])
                else $error("clear one did not zero its macrocell");

            comb_bypass_a : assert property ( // [R7]
                (!hold_off && mc_comb_cfg[gm]) |=> (mc_out_ff[gm] == $past(mc_d[gm])))
                else $error("combinatorial macrocell output mismatch");

            if (gm > 0) begin : g_chk
                expander_use_a : assert property ( // [R15]
                    (chain[gm-1] && !chain_pass_cfg[gm] && !xor_inv_cfg[gm]) |-> mc_d[gm])
                    else $error("incoming expander not seen by macrocell");
            end
        end
    endgenerate

    // Outputs to general routing and the local feedback lines.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mc_out_ff <= '0;
        end else begin
            mc_out_ff <= nxt_mc_out;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            local_fb_ff <= '0;
        end else begin
            local_fb_ff <= nxt_mc_out[NUM_FB-1:0]; // [R4] [R17]
        end
    end

    chip_clear_a : assert property ( // [R18]
        chip_clr |=> (mc_out_ff == '0 && mc_q == '0))
        else $error("chip-wide clear did not clear the array");

    mode_off_a : assert property ( // [R1]
        !block_pt_mode |=> (mc_out_ff == '0 && local_fb_ff == '0))
        else $error("array active outside macrocell mode");

    feedback_copy_a : assert property ( // [R4]
        local_fb_ff == mc_out_ff[NUM_FB-1:0])
        else $error("feedback lines differ from macrocell outputs");

    clear_status_a : assert property ( // [R13]
        ##1 (block_clear_one_ff == $past(clr_act[0]) && block_clear_two_ff == $past(clr_act[1])))
        else $error("block clear status lags wrongly");

endmodule // ptm_array

//--- tb/ptm_fabric.sv
`timescale 1ns/10ps
module ptm_fabric import ptm_pkg::*; (
    // Lines toward the block
    output logic [NUM_IN-1:0]  local_in,
    output logic [NUM_DED-1:0] ded_clk_pin,
    output logic [NUM_GLB-1:0] global_sig
);
    initial begin
        local_in    = '0;
        ded_clk_pin = '0;
        global_sig  = '0;
    end
    // Local routing carries literals, clocks, enables and clears into the block.
    task automatic set_line(input int idx, input logic v);
        local_in[idx] = v;
    endtask
    task automatic set_ded(input int idx, input logic v);
        ded_clk_pin[idx] = v;
    endtask
    task automatic set_glb(input int idx, input logic v);
        global_sig[idx] = v;
    endtask
endmodule // ptm_fabric

//--- tb/ptm_array_test.sv
`timescale 1ns/10ps
module ptm_array_test import ptm_pkg::*; ;
    logic ref_clk, sys_rst, clr_n, mode, c1, c2;
    logic [NUM_IN-1:0] loc;
    logic [NUM_DED-1:0] ded;
    logic [NUM_GLB-1:0] glb;
    logic [NUM_PT*NUM_IN-1:0] pt_t, pt_c;
    logic [NUM_PT-1:0] lend;
    logic [NUM_MC-1:0] inv1, pass, xinv, comb, csel, out;
    logic [NUM_FB-1:0] fbsel, fb;
    logic [2*NUM_MC-1:0] rtype, clrsel;
    logic [2*NUM_BCLK-1:0] csrc, clsrc;
    logic [IDX_W*NUM_BCLK-1:0] cidx, eidx, clidx;
    logic [NUM_BCLK-1:0] cfall, euse, clinv, tick;
    logic [2:0] tbl [4][3];
    int errors, samples_checked;

    ptm_fabric fab (.local_in(loc), .ded_clk_pin(ded), .global_sig(glb));

    ptm_array uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .global_register_clear_n(clr_n),
        .local_in(loc), .ded_clk_pin(ded), .global_sig(glb), .block_pt_mode(mode),
        .pt_true_cfg(pt_t), .pt_comp_cfg(pt_c), .pt_lend_cfg(lend), .pt1_inv_cfg(inv1),
        .chain_pass_cfg(pass), .xor_inv_cfg(xinv), .fb_sel_cfg(fbsel), .mc_comb_cfg(comb),
        .mc_regtype_cfg(rtype), .mc_clk_sel_cfg(csel), .mc_clr_sel_cfg(clrsel),
        .clk_src_cfg(csrc), .clk_idx_cfg(cidx), .clk_fall_cfg(cfall), .ena_use_cfg(euse),
        .ena_idx_cfg(eidx), .clr_src_cfg(clsrc), .clr_idx_cfg(clidx), .clr_inv_cfg(clinv),
        .mc_out_ff(out), .local_fb_ff(fb), .clk_tick_ff(tick),
        .block_clear_one_ff(c1), .block_clear_two_ff(c2)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("Checked %0d values, %0d mismatches", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic check_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_vec(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Gives up after a bounded number of cycles and closes the run.
    task automatic wait_out(input int i, input logic v);
        for (int k = 0; k < 12; k++) begin
            if (out[i] === v) return;
            step(1);
        end
        errors++;
        $display("Error mc_out_ff[%0d] expected %h seen %h", i, v, out[i]);
        summarize();
    endtask

    task automatic term(input int p, input logic [31:0] t, input logic [31:0] c);
        pt_t[p*NUM_IN+:NUM_IN] = t;
        pt_c[p*NUM_IN+:NUM_IN] = c;
    endtask

    // Rising edge on local line 10 with enable on line 11.
    task automatic pulse1(input logic en);
        fab.set_line(10, 1'b0);
        step(1);
        fab.set_line(11, en);
        fab.set_line(10, 1'b1);
        step(2);
    endtask

    initial begin
        errors = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        clr_n = 1'b1;
        mode = 1'b1;
        pt_t = '1;
        pt_c = '1;
        {lend, inv1, pass, xinv, fbsel, rtype, csel, clrsel, clinv} = '0;
        comb = '1;
        csrc = {SRC_DED, SRC_LOC};
        cidx = {5'h00, 5'h0a};
        cfall = 2'h2;
        euse = 2'h1;
        eidx = {5'h00, 5'h0b};
        clsrc = {SRC_GLB, SRC_LOC};
        clidx = {5'h01, 5'h0c};
        tbl = '{'{3'h5, 3'h0, 3'h5}, '{3'h5, 3'h4, 3'h0}, '{3'h5, 3'h1, 3'h6}, '{3'h5, 3'h7, 3'h2}};
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        step(4);
        check_vec("mc_out_ff", 16'h0000, out);
        $display("Test reset done");

        term(0, 32'h2, 32'h0);
        term(4, 32'h1, 32'h0);
        fbsel[0] = 1'b1;
        fab.set_line(0, 1'b1);
        fab.set_line(1, 1'b1);
        step(1);
        check_bit("mc_out_ff[0]", 1'b1, out[0]);
        wait_out(2, 1'b1);
        check_bit("local_fb_ff[0]", 1'b1, fb[0]);
        fab.set_line(1, 1'b0);
        step(1);
        check_bit("mc_out_ff[0]", 1'b0, out[0]);
        wait_out(2, 1'b0);
        $display("Test combinatorial done");

        inv1[3] = 1'b1;
        xinv[4] = 1'b1;
        step(1);
        check_bit("mc_out_ff[3]", 1'b1, out[3]);
        check_bit("mc_out_ff[4]", 1'b1, out[4]);
        term(10, 32'h4, 32'h0);
        lend[10] = 1'b1;
        fab.set_line(2, 1'b1);
        step(1);
        check_bit("mc_out_ff[6]", 1'b1, out[6]);
        check_bit("mc_out_ff[5]", 1'b0, out[5]);
        pass[6] = 1'b1;
        step(1);
        check_bit("mc_out_ff[7]", 1'b1, out[7]);
        check_bit("mc_out_ff[6]", 1'b0, out[6]);
        $display("Test expanders done");

        fbsel[0] = 1'b0;
        comb[9] = 1'b0;
        term(18, 32'h1, 32'h0);
        term(19, 32'h2, 32'h0);
        clrsel[19:18] = CLR_ONE;
        for (int t = 0; t < 4; t++) begin
            rtype[19:18] = t[1:0];
            fab.set_line(12, 1'b1);
            step(2);
            check_bit("clear one", 1'b0, out[9]);
            check_bit("block_clear_one_ff", 1'b1, c1);
            fab.set_line(12, 1'b0);
            for (int s = 0; s < 3; s++) begin
                fab.set_line(0, tbl[t][s][2]);
                fab.set_line(1, tbl[t][s][1]);
                pulse1(1'b1);
                check_bit("mc_out_ff[9]", tbl[t][s][0], out[9]);
            end
        end
        fab.set_line(0, 1'b1);
        fab.set_line(1, 1'b0);
        pulse1(1'b0);
        check_bit("disabled tick", 1'b0, out[9]);
        pulse1(1'b1);
        check_bit("enabled tick", 1'b1, out[9]);
        fab.set_line(10, 1'b0);
        step(1);
        fab.set_line(10, 1'b1);
        step(1);
        check_bit("clk_tick_ff[0]", 1'b1, tick[0]);
        step(1);
        check_bit("clk_tick_ff[0] end", 1'b0, tick[0]);
        $display("Test register types done");

        comb[10] = 1'b0;
        csel[10] = 1'b1;
        clrsel[21:20] = CLR_TWO;
        term(20, 32'h1, 32'h0);
        fab.set_ded(0, 1'b1);
        step(4);
        check_bit("rise on clock two", 1'b0, out[10]);
        fab.set_ded(0, 1'b0);
        wait_out(10, 1'b1);
        fab.set_glb(1, 1'b1);
        wait_out(10, 1'b0);
        check_bit("block_clear_two_ff", 1'b1, c2);
        clinv[1] = 1'b1;
        step(2);
        check_bit("inverted clear two", 1'b0, c2);
        fab.set_glb(1, 1'b0);
        clinv[1] = 1'b0;
        $display("Test clock two and clears done");

        fab.set_line(1, 1'b1);
        wait_out(0, 1'b1);
        clr_n = 1'b0;
        wait_out(9, 1'b0);
        check_vec("chip clear", 16'h0000, out);
        clr_n = 1'b1;
        wait_out(0, 1'b1);
        mode = 1'b0;
        wait_out(0, 1'b0);
        check_vec("memory mode", 16'h0000, out);
        mode = 1'b1;
        wait_out(0, 1'b1);
        $display("Test chip clear and mode done");
        summarize();
    end
endmodule // ptm_array_test
